// file: design/phy_status_defines.vh
/*
 Register offsets, field positions, reset values and event codes for the basic status
 and identifier register slice. Definitions only; included by the top design module only.
*/
// Functional notes
// - Status bit 15 always reads zero: no four-pair 100 Mb/s ability.
// - Status bits 14 to 11 read-only, reset zero: no 100X or 10 Mb/s abilities.
// - Status bit 4 is a hardware-set remote fault flag, reset zero.
// - Status bit 3 reads zero: no auto-negotiation ability.
// - Status bit 2 shows link state, one when up, reset zero.
// - Status bit 1 is a hardware-set jabber flag, reset zero.
// - Status bit 0 reads one: extended registers exist.
// - Basic status at 1h, identifier high at 2h, low at 3h; 16 bits each.
// - Identifier high holds vendor identifier bits 21 to 6, read-only constant.
// - Identifier low: vendor bits 5-0, six-bit model, four-bit revision, constant.
`ifndef PHY_STATUS_DEFINES_VH
`define PHY_STATUS_DEFINES_VH

// ==========================================================
// Register indices; byte address is four times the index
`define IDX_BASIC_STATUS 4'h1
`define IDX_IDENTIFIER_HIGH 4'h2
`define IDX_IDENTIFIER_LOW 4'h3
`define IDX_IRQ_STATUS 4'h8
`define IDX_IRQ_MASK 4'h9

// ==========================================================
// Basic status field positions
`define BIT_T4_ABLE 15
`define BIT_PREAMBLE_SKIP 6
`define BIT_ANEG_DONE 5
`define BIT_REMOTE_FAULT 4
`define BIT_ANEG_ABLE 3
`define BIT_LINK_UP 2
`define BIT_JABBER 1
`define BIT_EXT_CAP 0
`define BASIC_STATUS_RESET 16'h0061

// ==========================================================
// Interrupt event bits
`define EV_REMOTE_FAULT 0
`define EV_JABBER 1
`define EV_LINK_CHANGE 2
`define EV_WIDTH 3

// ==========================================================
// Identifier field positions
`define ID_VENDOR_LO_MSB 15
`define ID_VENDOR_LO_LSB 10
`define ID_MODEL_MSB 9
`define ID_MODEL_LSB 4
`define ID_REV_MSB 3
`define ID_REV_LSB 0

`endif

// file: design/sticky_flag.v
/*
 One sticky flag: set by a hardware event, cleared by a clear pulse.
 Assumes event and clear are synchronous to clk.
*/
`timescale 1ns/1ns
module sticky_flag
(
    input wire clk,
    input wire rst_n,
    input wire set,
    input wire clear,
    output reg flag
);

// Set wins over a clear in the same cycle so no event is lost
always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
        flag <= 1'b0;
    else if (set)
        flag <= 1'b1;
    else if (clear)
        flag <= 1'b0;
end

endmodule

// file: design/avalon_slave_ctl.v
/*
 Avalon-MM handshake for the register slice: every access takes exactly one wait cycle.
 Assumes the master holds a request until it sees waitrequest low.
*/
`timescale 1ns/1ns
module avalon_slave_ctl
(
    input wire clk,
    input wire rst_n,
    input wire read,
    input wire write,
    output wire waitrequest,
    output reg accept
);

// accept marks the edge at which the request completes
always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
        accept <= 1'b0;
    else
        accept <= (read || write) && !accept;
end

assign waitrequest = (read || write) && !accept;

endmodule

// file: design/phy_basic_status_and_id_regs.v
/*
 Basic status and identifier registers of a single-pair Ethernet transceiver,
 behind an Avalon-MM slave with one wait cycle, plus a small interrupt block.
 Assumes link, fault and jabber inputs are synchronous to clk.
*/
`timescale 1ns/1ns
`include "phy_status_defines.vh"
module phy_basic_status_and_id_regs
#(
    parameter [5:0] VENDOR_ID_LO = 6'h15,
    parameter [15:0] VENDOR_ID_HI = 16'h1234,
    parameter [5:0] MODEL_NUMBER = 6'h0A,
    parameter [3:0] REVISION = 4'h1
)
(
    input wire clk,
    input wire rst_n,
    input wire [3:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    output reg [31:0] readdata,
    output wire waitrequest,
    output reg irq,
    input wire link_up_in,
    input wire remote_fault_event,
    input wire jabber_event
);
// Vendor, model and revision defaults are arbitrary values

// ==========================================================
// Bus handshake
wire accept;

avalon_slave_ctl u_ctl
(
    .clk(clk),
    .rst_n(rst_n),
    .read(read),
    .write(write),
    .waitrequest(waitrequest),
    .accept(accept)
);

// Request is still held at the accepting edge, so decode it there
wire rd_now = read && waitrequest == 1'b0;
wire wr_now = write && waitrequest == 1'b0;

// ==========================================================
// Link state and latched flags
reg link_up;
reg link_prev;
wire remote_fault;
wire jabber;
wire clear_latched;

always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        link_up <= 1'b0;
        link_prev <= 1'b0;
    end
    else
    begin
        link_up <= link_up_in;
        link_prev <= link_up;
    end
end

// Clears only after the status read has completed on the bus
assign clear_latched = rd_now && (address == `IDX_BASIC_STATUS);

sticky_flag u_fault
(
    .clk(clk),
    .rst_n(rst_n),
    .set(remote_fault_event),
    .clear(clear_latched),
    .flag(remote_fault)
);

sticky_flag u_jabber
(
    .clk(clk),
    .rst_n(rst_n),
    .set(jabber_event),
    .clear(clear_latched),
    .flag(jabber)
);

// ==========================================================
// Register images
wire [15:0] basic_status;
wire [15:0] identifier_high;
wire [15:0] identifier_low;

assign basic_status = {1'b0,
                       4'h0,
                       4'h0,
                       1'b1,
                       1'b1,
                       remote_fault,
                       1'b0,
                       link_up,
                       jabber,
                       1'b1};

assign identifier_high = VENDOR_ID_HI;
assign identifier_low = {VENDOR_ID_LO, MODEL_NUMBER, REVISION};

// ==========================================================
// Interrupts: sticky status cleared by read, mask same layout
wire [`EV_WIDTH-1:0] ev;
wire [`EV_WIDTH-1:0] irq_status;
reg [`EV_WIDTH-1:0] irq_mask;
wire clear_irq;

assign ev = {link_up != link_prev, jabber_event, remote_fault_event};
assign clear_irq = rd_now && (address == `IDX_IRQ_STATUS);

genvar g;
generate
    for (g = 0; g < `EV_WIDTH; g = g + 1)
    begin : gen_ev
        sticky_flag u_ev
        (
            .clk(clk),
            .rst_n(rst_n),
            .set(ev[g]),
            .clear(clear_irq),
            .flag(irq_status[g])
        );
    end
endgenerate

always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
        irq_mask <= {`EV_WIDTH{1'b0}};
    else if (wr_now && address == `IDX_IRQ_MASK)
        irq_mask <= writedata[`EV_WIDTH-1:0];
end

always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
        irq <= 1'b0;
    else
        irq <= |(irq_status & irq_mask);
end

// ==========================================================
// Read mux; unmapped indices read zero, writes there are ignored
reg [31:0] next_readdata;

always @*
begin
    case (address)
        `IDX_BASIC_STATUS: next_readdata = {16'h0000, basic_status};
        `IDX_IDENTIFIER_HIGH: next_readdata = {16'h0000, identifier_high};
        `IDX_IDENTIFIER_LOW: next_readdata = {16'h0000, identifier_low};
        `IDX_IRQ_STATUS: next_readdata = {29'h0, irq_status};
        `IDX_IRQ_MASK: next_readdata = {29'h0, irq_mask};
        default: next_readdata = 32'h0000_0000;
    endcase
end

// Data is captured during the wait cycle and stands at the accepting edge
always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
        readdata <= 32'h0000_0000;
    else if (read && !accept)
        readdata <= next_readdata;
end

endmodule

// file: testbench/phy_regs_assertions.sv
/* Port assertions for the status and identifier slice.
   Assumes it is bound to the slice top and sees one clock. */
`timescale 1ns/1ns
module phy_regs_assertions
(
    input wire clk,
    input wire rst_n,
    input wire [3:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    input wire [31:0] readdata,
    input wire waitrequest,
    input wire irq,
    input wire link_up_in,
    input wire remote_fault_event,
    input wire jabber_event
);
    // ==========
    // Completed status reads
    wire st = read && !waitrequest && address == 4'h1;
    wire req = read || write;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    t4_zero_a: assert property (st |-> !readdata[15]) else $error("t4 set");
    ability_zero_a: assert property (st |-> readdata[14:11] == 4'h0) else $error("ability");
    aneg_zero_a: assert property (st |-> !readdata[3]) else $error("aneg set");
    ext_cap_a: assert property (st |-> readdata[0]) else $error("ext cap");
    fixed_mid_a: assert property (st |-> readdata[10:5] == 6'h03) else $error("bits 10:5");
    upper_zero_a: assert property (st |-> readdata[31:16] == 16'h0) else $error("upper");
    first_wait_a: assert property (req && !$past(req) |-> waitrequest) else $error("wait");
    link_follow_a: assert property (st && $stable(link_up_in)
        && $past(link_up_in) == $past(link_up_in, 2) |-> readdata[2] == link_up_in)
        else $error("link bit");
    fault_latch_a: assert property ($past(remote_fault_event, 2) && st |-> readdata[4])
        else $error("fault bit");
    jabber_latch_a: assert property ($past(jabber_event, 2) && st |-> readdata[1])
        else $error("jabber bit");
    cover property (st && readdata[4]);
    cover property (st && readdata[1]);
    cover property (irq);
endmodule

// file: testbench/mgmt_master.sv
/* Avalon-MM management master model with one access task.
   Assumes the slave answers by lowering waitrequest. */
`timescale 1ns/1ns
module mgmt_master
(
    input wire clk,
    output reg [3:0] address,
    output reg read,
    output reg write,
    output reg [31:0] writedata,
    input wire [31:0] readdata,
    input wire waitrequest
);
    initial
    begin
        address = 4'h0;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
    end
    // ==========
    // Released address and writedata lines show inverted values so stale data cannot pass
    task automatic access(input logic w, input logic [3:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge clk);
        address <= a;
        read <= !w;
        write <= w;
        writedata <= d;
        do @(posedge clk); while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        address <= ~a;
        writedata <= ~d;
    endtask
endmodule

// file: testbench/tb.sv
/* Self-checking bench for the status and identifier slice.
   Assumes the master model and the checker files are compiled first. */
`timescale 1ns/1ns
module tb;
    // Identity values are arbitrary
    localparam [15:0] VH = 16'h5A3C;
    localparam [5:0] VL = 6'h2B;
    localparam [5:0] MD = 6'h11;
    localparam [3:0] RV = 4'h7;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg link = 1'b0;
    reg rf = 1'b0;
    reg jb = 1'b0;
    wire [3:0] address;
    wire read, write, waitrequest, irq;
    wire [31:0] writedata, readdata;
    reg [31:0] q;
    integer fail_count = 0;
    integer n_tests = 0;
    always #2 clk = ~clk;
    phy_basic_status_and_id_regs #(.VENDOR_ID_LO(VL), .VENDOR_ID_HI(VH), .MODEL_NUMBER(MD),
        .REVISION(RV)) dut_u (.clk(clk), .rst_n(rst_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .irq(irq), .link_up_in(link), .remote_fault_event(rf), .jabber_event(jb));
    mgmt_master m_u (.clk(clk), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest));
    // ==========
    // Shared tasks
    task check(input string nm, input [31:0] e, input [31:0] g);
        n_tests = n_tests + 1;
        if (g !== e)
        begin
            fail_count = fail_count + 1;
            $display("CHECK FAILED %0s exp %h got %h", nm, e, g);
        end
    endtask
    task rd(input [3:0] a, input [31:0] e, input string nm);
        m_u.access(1'b0, a, 32'h0, q);
        check(nm, e, q);
    endtask
    task pulse(input logic k);
        @(posedge clk);
        if (k) rf <= 1'b1; else jb <= 1'b1;
        @(posedge clk);
        rf <= 1'b0;
        jb <= 1'b0;
    endtask
    task t_ids;
        rd(4'h2, {16'h0, VH}, "id_high");
        rd(4'h3, {16'h0, VL, MD, RV}, "id_low");
        rd(4'hF, 32'h0, "unmapped");
        m_u.access(1'b1, 4'h1, 32'hFFFF, q);
        rd(4'h1, 32'h61, "status after write");
    endtask
    task t_link;
        @(posedge clk) link <= 1'b1;
        rd(4'h1, 32'h65, "link up");
        @(posedge clk) link <= 1'b0;
        rd(4'h1, 32'h61, "link down");
    endtask
    task t_latch;
        pulse(1'b1);
        rd(4'h1, 32'h71, "fault set");
        rd(4'h1, 32'h61, "fault cleared");
        pulse(1'b0);
        rd(4'h1, 32'h63, "jabber set");
        rd(4'h1, 32'h61, "jabber cleared");
    endtask
    task t_irq;
        rd(4'h8, 32'h7, "irq status");
        m_u.access(1'b1, 4'h9, 32'h1, q);
        pulse(1'b0);
        repeat (3) @(posedge clk);
        check("irq masked", 32'h0, {31'h0, irq});
        pulse(1'b1);
        repeat (3) @(posedge clk);
        check("irq raised", 32'h1, {31'h0, irq});
        rd(4'h8, 32'h3, "irq status two");
        repeat (3) @(posedge clk);
        check("irq cleared", 32'h0, {31'h0, irq});
    endtask
    task stop_test;
        if (fail_count == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd(4'h1, 32'h61, "status reset");
        t_ids;
        t_link;
        t_latch;
        t_irq;
        stop_test;
    end
    initial
    begin
        repeat (3000) @(posedge clk);
        fail_count = fail_count + 1;
        stop_test;
    end
endmodule
bind phy_basic_status_and_id_regs phy_regs_assertions chk_u (.clk(clk), .rst_n(rst_n),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .irq(irq), .link_up_in(link_up_in),
    .remote_fault_event(remote_fault_event), .jabber_event(jabber_event));
